// ==== hw/mcsb_pkg.sv ====
// package for the motor control status bank: offsets, reset values, state codes
package mcsb_pkg;

	// ****************************************************************
	// register indices (printed offsets are not all multiples of four)
	// ****************************************************************
	localparam logic [11:0] MCSB_IDX_CONTROL_PHASE_STATUS    = 12'h210;
	localparam logic [11:0] MCSB_IDX_PULSE_SPEED_ESTIMATE    = 12'h216;
	localparam logic [11:0] MCSB_IDX_SUPPLY_CURRENT_ESTIMATE = 12'h410;
	localparam logic [11:0] MCSB_IDX_INITIAL_ROTOR_ANGLE     = 12'h6FC;
	localparam logic [11:0] MCSB_IDX_BACKEMF_D_AXIS          = 12'h742;
	localparam logic [11:0] MCSB_IDX_BACKEMF_Q_AXIS          = 12'h744;
	localparam logic [11:0] MCSB_IDX_ESTIMATED_ROTOR_SPEED   = 12'h752;
	localparam logic [11:0] MCSB_IDX_ESTIMATED_ROTOR_POS     = 12'h756;
	// interrupt registers, placed above the documented bank
	localparam logic [11:0] MCSB_IDX_IRQ_STATUS              = 12'hF00;
	localparam logic [11:0] MCSB_IDX_IRQ_ENABLE              = 12'hF01;
	localparam logic [11:0] MCSB_IDX_IRQ_CLEAR               = 12'hF02;

	// ****************************************************************
	// field layout and reset values
	// ****************************************************************
	localparam int          MCSB_STATE_MSB    = 15;
	localparam logic [31:0] MCSB_RESET_WORD   = 32'h00000000;
	localparam logic [15:0] MCSB_RESET_STATE  = 16'h0000;
	localparam logic [2:0]  MCSB_RESET_IRQ    = 3'h0;
	localparam int          MCSB_IRQ_STATE    = 0;
	localparam int          MCSB_IRQ_FAULT    = 1;
	localparam int          MCSB_IRQ_WRITE    = 2;

	// ****************************************************************
	// control-sequence state codes
	// ****************************************************************
	localparam logic [15:0] MCSB_ST_IDLE        = 16'h0000;
	localparam logic [15:0] MCSB_ST_SPEED_DET   = 16'h0001;
	localparam logic [15:0] MCSB_ST_TRISTATE    = 16'h0002;
	localparam logic [15:0] MCSB_ST_START_BRAKE = 16'h0003;
	localparam logic [15:0] MCSB_ST_POS_DET     = 16'h0004;
	localparam logic [15:0] MCSB_ST_SLOW_FIRST  = 16'h0005;
	localparam logic [15:0] MCSB_ST_ALIGN       = 16'h0006;
	localparam logic [15:0] MCSB_ST_OPEN_LOOP   = 16'h0007;
	localparam logic [15:0] MCSB_ST_CLOSED_MIN  = 16'h0008;
	localparam logic [15:0] MCSB_ST_CLOSED_MAX  = 16'h000A;
	localparam logic [15:0] MCSB_ST_STOP_MIN    = 16'h000B;
	localparam logic [15:0] MCSB_ST_STOP_MAX    = 16'h000D;
	localparam logic [15:0] MCSB_ST_FAULT       = 16'h000E;
	localparam logic [15:0] MCSB_ST_MEAS_MIN    = 16'h000F;
	localparam logic [15:0] MCSB_ST_MEAS_MAX    = 16'h0018;

	// bus handshake phases
	typedef enum logic [1:0] {
		MCSB_BUS_IDLE,
		MCSB_BUS_ANSWER,
		MCSB_BUS_DONE
	} mcsb_bus_t;

endpackage : mcsb_pkg

// ==== hw/mcsb_status_bank.sv ====
// read-only status register bank for the motor control algorithm, avalon-mm slave
`timescale 1ns/1ns
`default_nettype none

module mcsb_status_bank
	import mcsb_pkg::*;
(
	input  wire logic        clk_sys_in,
	input  wire logic        rst_b_in,
	// avalon-mm slave, word address = register index
	input  wire logic [11:0] avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic [3:0]  avs_byteenable_in,
	output logic      [31:0] avs_readdata_out,
	output logic             avs_waitrequest_out,
	output logic      [1:0]  avs_response_out,
	// live values from the control algorithm
	input  wire logic [15:0] phase_state_in,
	input  wire logic [31:0] pulse_speed_in,
	input  wire logic [31:0] supply_current_in,
	input  wire logic [31:0] initial_angle_in,
	input  wire logic [31:0] backemf_d_in,
	input  wire logic [31:0] backemf_q_in,
	input  wire logic [31:0] rotor_speed_in,
	input  wire logic [31:0] rotor_position_in,
	input  wire logic        update_in,
	output logic             irq_out
);

	// ****************************************************************
	// snapshot registers
	// ****************************************************************
	logic [15:0] state_q;
	logic [15:0] state_d;
	logic [31:0] pulse_speed_q;
	logic [31:0] pulse_speed_d;
	logic [31:0] supply_current_q;
	logic [31:0] supply_current_d;
	logic [31:0] initial_angle_q;
	logic [31:0] initial_angle_d;
	logic [31:0] backemf_d_q;
	logic [31:0] backemf_d_d;
	logic [31:0] backemf_q_q;
	logic [31:0] backemf_q_d;
	logic [31:0] rotor_speed_q;
	logic [31:0] rotor_speed_d;
	logic [31:0] rotor_position_q;
	logic [31:0] rotor_position_d;

	// values load together on update so a host sees one coherent sample
	assign state_d          = update_in ? phase_state_in    : state_q;
	assign pulse_speed_d    = update_in ? pulse_speed_in    : pulse_speed_q;
	assign supply_current_d = update_in ? supply_current_in : supply_current_q;
	assign initial_angle_d  = update_in ? initial_angle_in  : initial_angle_q;
	assign backemf_d_d      = update_in ? backemf_d_in      : backemf_d_q;
	assign backemf_q_d      = update_in ? backemf_q_in      : backemf_q_q;
	assign rotor_speed_d    = update_in ? rotor_speed_in    : rotor_speed_q;
	assign rotor_position_d = update_in ? rotor_position_in : rotor_position_q;

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			state_q <= MCSB_RESET_STATE;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			pulse_speed_q <= MCSB_RESET_WORD;
		end else begin
			pulse_speed_q <= pulse_speed_d;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			supply_current_q <= MCSB_RESET_WORD;
		end else begin
			supply_current_q <= supply_current_d;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			initial_angle_q <= MCSB_RESET_WORD;
		end else begin
			initial_angle_q <= initial_angle_d;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			backemf_d_q <= MCSB_RESET_WORD;
		end else begin
			backemf_d_q <= backemf_d_d;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			backemf_q_q <= MCSB_RESET_WORD;
		end else begin
			backemf_q_q <= backemf_q_d;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			rotor_speed_q <= MCSB_RESET_WORD;
		end else begin
			rotor_speed_q <= rotor_speed_d;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			rotor_position_q <= MCSB_RESET_WORD;
		end else begin
			rotor_position_q <= rotor_position_d;
		end
	end

	// ****************************************************************
	// bus decode
	// ****************************************************************
	mcsb_bus_t   bus_q;
	mcsb_bus_t   bus_d;
	logic [2:0]  irq_status_q;
	logic [2:0]  irq_status_d;
	logic [2:0]  irq_enable_q;
	logic [2:0]  irq_enable_d;
	logic        req;
	logic        wr_take;
	logic        hit;
	logic        sel_state;
	logic        sel_pulse_speed;
	logic        sel_supply_current;
	logic        sel_initial_angle;
	logic        sel_backemf_d;
	logic        sel_backemf_q;
	logic        sel_rotor_speed;
	logic        sel_rotor_position;
	logic        sel_irq_status;
	logic        sel_irq_enable;
	logic        sel_irq_clear;
	logic [31:0] state_word;
	logic [31:0] read_word;

	// a deselected register adds zero, so the read word is a plain or
	function automatic logic [31:0] pick_word(input logic sel, input logic [31:0] word);
		pick_word = sel ? word : MCSB_RESET_WORD;
	endfunction : pick_word

	assign req     = (avs_read_in || avs_write_in) && (bus_q == MCSB_BUS_IDLE);
	assign wr_take = req && avs_write_in;

	assign sel_state          = (avs_address_in == MCSB_IDX_CONTROL_PHASE_STATUS);
	assign sel_pulse_speed    = (avs_address_in == MCSB_IDX_PULSE_SPEED_ESTIMATE);
	assign sel_supply_current = (avs_address_in == MCSB_IDX_SUPPLY_CURRENT_ESTIMATE);
	assign sel_initial_angle  = (avs_address_in == MCSB_IDX_INITIAL_ROTOR_ANGLE);
	assign sel_backemf_d      = (avs_address_in == MCSB_IDX_BACKEMF_D_AXIS);
	assign sel_backemf_q      = (avs_address_in == MCSB_IDX_BACKEMF_Q_AXIS);
	assign sel_rotor_speed    = (avs_address_in == MCSB_IDX_ESTIMATED_ROTOR_SPEED);
	assign sel_rotor_position = (avs_address_in == MCSB_IDX_ESTIMATED_ROTOR_POS);
	assign sel_irq_status     = (avs_address_in == MCSB_IDX_IRQ_STATUS);
	assign sel_irq_enable     = (avs_address_in == MCSB_IDX_IRQ_ENABLE);
	assign sel_irq_clear      = (avs_address_in == MCSB_IDX_IRQ_CLEAR);
	assign hit = sel_state | sel_pulse_speed | sel_supply_current | sel_initial_angle
		| sel_backemf_d | sel_backemf_q | sel_rotor_speed | sel_rotor_position
		| sel_irq_status | sel_irq_enable | sel_irq_clear;

	assign state_word = {16'h0000, state_q[MCSB_STATE_MSB:0]};

	// the clear register has no pick: it always reads zero
	assign read_word = pick_word(sel_state, state_word)
		| pick_word(sel_pulse_speed, pulse_speed_q)
		| pick_word(sel_supply_current, supply_current_q)
		| pick_word(sel_initial_angle, initial_angle_q)
		| pick_word(sel_backemf_d, backemf_d_q)
		| pick_word(sel_backemf_q, backemf_q_q)
		| pick_word(sel_rotor_speed, rotor_speed_q)
		| pick_word(sel_rotor_position, rotor_position_q)
		| pick_word(sel_irq_status, {29'h00000000, irq_status_q})
		| pick_word(sel_irq_enable, {29'h00000000, irq_enable_q});

	// ****************************************************************
	// interrupt events
	// ****************************************************************
	logic       irq_q;
	logic       irq_d;
	logic [2:0] irq_event;
	logic [2:0] irq_clear;

	function automatic logic is_fault_code(input logic [15:0] code);
		is_fault_code = (code == MCSB_ST_FAULT) || (code == MCSB_ST_MEAS_MAX);
	endfunction : is_fault_code

	// events: state change, entry to a fault state, write to a mapped register other than irq enable and clear
	assign irq_event[MCSB_IRQ_STATE] = update_in && (phase_state_in != state_q);
	assign irq_event[MCSB_IRQ_FAULT] = update_in && is_fault_code(phase_state_in)
		&& !is_fault_code(state_q);
	assign irq_event[MCSB_IRQ_WRITE] = wr_take && hit
		&& !sel_irq_enable && !sel_irq_clear;
	assign irq_clear = (wr_take && sel_irq_clear) ? avs_writedata_in[2:0] : MCSB_RESET_IRQ;
	// a new event wins over a clear in the same cycle
	assign irq_status_d = (irq_status_q & ~irq_clear) | irq_event;
	assign irq_enable_d = (wr_take && sel_irq_enable && avs_byteenable_in[0])
		? avs_writedata_in[2:0] : irq_enable_q;
	// the level lags the enable by a cycle so that irq_out stays on a flip-flop
	assign irq_d = |(irq_status_d & irq_enable_q);

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			irq_status_q <= MCSB_RESET_IRQ;
		end else begin
			irq_status_q <= irq_status_d;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			irq_enable_q <= MCSB_RESET_IRQ;
		end else begin
			irq_enable_q <= irq_enable_d;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= irq_d;
		end
	end

	// ****************************************************************
	// handshake: waitrequest drops one cycle after the request is seen
	// ****************************************************************
	// registering the answer keeps every output straight from a flip-flop,
	// at the cost of one wait cycle per access
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [1:0]  resp_q;
	logic [1:0]  resp_d;
	logic        wait_d;

	always_comb begin
		bus_d = bus_q;
		unique case (bus_q)
			MCSB_BUS_IDLE:   bus_d = req ? MCSB_BUS_ANSWER : MCSB_BUS_IDLE;
			MCSB_BUS_ANSWER: bus_d = MCSB_BUS_DONE;
			MCSB_BUS_DONE:   bus_d = MCSB_BUS_IDLE;
			default:         bus_d = MCSB_BUS_IDLE;
		endcase
	end

	// read data and response stand for two cycles, then fall back to zero
	assign rdata_d = req ? (avs_read_in ? read_word : MCSB_RESET_WORD)
		: (bus_q == MCSB_BUS_DONE) ? MCSB_RESET_WORD
		: rdata_q;
	assign resp_d = req ? (hit ? 2'h0 : 2'h3)
		: (bus_q == MCSB_BUS_DONE) ? 2'h0
		: resp_q;
	assign wait_d = !req;

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			bus_q <= MCSB_BUS_IDLE;
		end else begin
			bus_q <= bus_d;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			rdata_q <= MCSB_RESET_WORD;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			resp_q <= 2'h0;
		end else begin
			resp_q <= resp_d;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			avs_waitrequest_out <= 1'b1;
		end else begin
			avs_waitrequest_out <= wait_d;
		end
	end

	assign avs_readdata_out = rdata_q;
	assign avs_response_out = resp_q;
	assign irq_out          = irq_q;

endmodule : mcsb_status_bank

`default_nettype wire

// ==== testbench/mcsb_status_bank_props.sv ====
// assertions on the status bank's bus and read values
`timescale 1ns/1ns
`default_nettype none
module mcsb_status_bank_props
	import mcsb_pkg::*;
(
	input  wire logic        clk_sys_in,
	input  wire logic        rst_b_in,
	input  wire logic [11:0] avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_readdata_out,
	input  wire logic        avs_waitrequest_out,
	input  wire logic [1:0]  avs_response_out,
	input  wire logic [15:0] phase_state_in,
	input  wire logic [31:0] rotor_speed_in,
	input  wire logic        update_in
);
	logic [15:0] st_q;
	logic [31:0] spd_q;
	logic        rd_ok;
	assign rd_ok = avs_read_in && !avs_waitrequest_out;
	// shadow of the last captured values; bench never updates during a read
	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			st_q  <= 16'h0000;
			spd_q <= 32'h00000000;
		end else if (update_in) begin
			st_q  <= phase_state_in;
			spd_q <= rotor_speed_in;
		end
	end
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_b_in);
	AST_WAIT_ONE: assert property (!avs_waitrequest_out |=> avs_waitrequest_out[*2])
		else $error("waitrequest low too long");
	AST_TAKE: assert property ((avs_read_in || avs_write_in) |-> ##[0:3] !avs_waitrequest_out)
		else $error("request not answered");
	AST_RD_IDLE: assert property (avs_waitrequest_out && $past(avs_waitrequest_out)
		|-> avs_readdata_out == 32'h00000000)
		else $error("read data not cleared");
	AST_RESET: assert property ($rose(rst_b_in) |-> avs_waitrequest_out && !avs_readdata_out)
		else $error("bus not quiet after reset");
	AST_UPPER_ZERO: assert property (rd_ok && avs_address_in == MCSB_IDX_CONTROL_PHASE_STATUS
		|-> avs_readdata_out[31:16] == 16'h0000)
		else $error("state upper bits set");
	AST_STATE_VAL: assert property (rd_ok && avs_address_in == MCSB_IDX_CONTROL_PHASE_STATUS
		|-> avs_readdata_out[15:0] == st_q && avs_response_out == 2'h0)
		else $error("state read wrong");
	AST_SPEED_VAL: assert property (rd_ok && avs_address_in == MCSB_IDX_ESTIMATED_ROTOR_SPEED
		|-> avs_readdata_out == spd_q)
		else $error("rotor speed read wrong");
	AST_UNMAPPED: assert property (rd_ok && avs_address_in == 12'h100
		|-> avs_response_out == 2'h3 && avs_readdata_out == 32'h00000000)
		else $error("unmapped read answered");
endmodule : mcsb_status_bank_props
bind mcsb_status_bank mcsb_status_bank_props u_props (.clk_sys_in(clk_sys_in),
	.rst_b_in(rst_b_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
	.avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
	.avs_waitrequest_out(avs_waitrequest_out), .avs_response_out(avs_response_out),
	.phase_state_in(phase_state_in), .rotor_speed_in(rotor_speed_in), .update_in(update_in));
`default_nettype wire

// ==== testbench/mcsb_status_bank_tb.sv ====
// self-checking bench for the status bank
`timescale 1ns/1ns
`default_nettype none
module mcsb_status_bank_tb
	import mcsb_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic        upd = 1'b0;
	logic [11:0] addr = 12'h000;
	logic [31:0] wdata = 32'h00000000;
	logic [31:0] val [0:7];
	logic [11:0] idx [0:7];
	logic [31:0] rdata;
	logic [1:0]  resp;
	logic        waitreq;
	logic        irq;
	logic [33:0] exp_q [$];
	int          num_errors = 0;
	int          n_checks = 0;
	int          seed = 32'hE7EFB809;
	int          i;
	always #20 clk = ~clk;
	mcsb_status_bank DUT (.clk_sys_in(clk), .rst_b_in(rst_b), .avs_address_in(addr),
		.avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
		.avs_byteenable_in(4'hF), .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
		.avs_response_out(resp), .phase_state_in(val[0][15:0]), .pulse_speed_in(val[1]),
		.supply_current_in(val[2]), .initial_angle_in(val[3]), .backemf_d_in(val[4]),
		.backemf_q_in(val[5]), .rotor_speed_in(val[6]), .rotor_position_in(val[7]),
		.update_in(upd), .irq_out(irq));
	// ****************************************
	// checking and bus tasks
	// ****************************************
	task automatic check(input logic [33:0] seen, input logic [33:0] want);
		n_checks++;
		if (seen !== want) begin
			num_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : check
	task automatic end_of_test;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : end_of_test
	// a read notes its expected {response, data}; the monitor compares it
	task automatic bus(input logic w, input logic [11:0] a, input logic [33:0] d);
		int n;
		n = 0;
		if (!w) exp_q.push_back(d);
		rd <= !w;
		wr <= w;
		addr <= a;
		wdata <= d[31:0];
		do begin @(posedge clk); n++; end while (waitreq !== 1'b0 && n < 50);
		if (n >= 50) check(34'h0, 34'h1);
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk);
	endtask : bus
	task automatic load;
		upd <= 1'b1;
		@(posedge clk);
		upd <= 1'b0;
		@(posedge clk);
	endtask : load
	task automatic irq_is(input logic e);
		repeat (2) @(posedge clk);
		check({33'h0, irq}, {33'h0, e});
	endtask : irq_is
	always @(posedge clk) if (rd && waitreq === 1'b0) check({resp, rdata}, exp_q.pop_front());
	initial begin
		#(40 * 5000);
		num_errors++;
		end_of_test();
	end
	initial begin
		idx = '{MCSB_IDX_CONTROL_PHASE_STATUS, MCSB_IDX_PULSE_SPEED_ESTIMATE,
			MCSB_IDX_SUPPLY_CURRENT_ESTIMATE, MCSB_IDX_INITIAL_ROTOR_ANGLE, MCSB_IDX_BACKEMF_D_AXIS,
			MCSB_IDX_BACKEMF_Q_AXIS, MCSB_IDX_ESTIMATED_ROTOR_SPEED, MCSB_IDX_ESTIMATED_ROTOR_POS};
		for (i = 0; i < 8; i++) val[i] = 32'h00000000;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		for (i = 0; i < 8; i++) bus(1'b0, idx[i], 34'h0);
		bus(1'b0, 12'h100, {2'h3, 32'h0});
		for (i = 0; i < 8; i++) val[i] <= $random(seed);
		load();
		for (i = 0; i < 8; i++) bus(1'b1, idx[i], {2'h0, $random(seed)});
		for (i = 0; i < 8; i++) bus(1'b0, idx[i], {2'h0, i ? val[i] : {16'h0, val[0][15:0]}});
		for (i = 0; i <= 24; i++) begin
			val[0] <= 32'hFFFF0000 | i;
			load();
			bus(1'b0, idx[0], {18'h0, i[15:0]});
		end
		bus(1'b1, MCSB_IDX_IRQ_ENABLE, 34'h7);
		bus(1'b0, MCSB_IDX_IRQ_STATUS, 34'h7);
		irq_is(1'b1);
		bus(1'b1, MCSB_IDX_IRQ_CLEAR, 34'h7);
		bus(1'b0, MCSB_IDX_IRQ_STATUS, 34'h0);
		irq_is(1'b0);
		bus(1'b1, idx[6], 34'h5);
		irq_is(1'b1);
		bus(1'b1, MCSB_IDX_IRQ_ENABLE, 34'h0);
		irq_is(1'b0);
		bus(1'b0, MCSB_IDX_IRQ_STATUS, 34'h4);
		bus(1'b0, MCSB_IDX_IRQ_CLEAR, 34'h0);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		bus(1'b0, idx[0], 34'h0);
		end_of_test();
	end
endmodule : mcsb_status_bank_tb
`default_nettype wire
